/* hw/cbaop_core.sv */
`timescale 1ns/10ps
`default_nettype none
module cbaop_core
  import cbaop_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic watchdog_expire_evt,
  input wire logic powerdown_evt,
  output logic watchdog_clear
);

  // data memory location, accumulator and status state
  logic [7:0] mem_reg;
  logic [7:0] mem_next;
  logic [7:0] acc_reg;
  logic [7:0] acc_next;
  cbaop_flags_t flags_reg;
  cbaop_flags_t flags_next;
  logic wdclr_reg;
  logic wdclr_next;

  wire wr_en = psel && penable && pwrite;
  wire hit_ctrl = (paddr == CBAOP_OFF_CTRL);
  wire hit_opnd = (paddr == CBAOP_OFF_OPERAND);
  wire hit_acc = (paddr == CBAOP_OFF_ACC);
  wire hit_st = (paddr == CBAOP_OFF_STATUS);
  wire mapped = hit_ctrl || hit_opnd || hit_acc || hit_st;
  wire go = wr_en && hit_ctrl && pstrb[0] && pwdata[CBAOP_CTRL_GO_BIT];
  cbaop_op_t op;
  assign op = cbaop_op_t'(pwdata[CBAOP_CTRL_OP_LSB +: CBAOP_CTRL_OP_W]);

  // lane 0 write strobes per register
  wire wr_opnd = wr_en && hit_opnd && pstrb[0];
  wire wr_acc = wr_en && hit_acc && pstrb[0];
  wire wr_st = wr_en && hit_st && pstrb[0];

  // one strobe per operation
  wire do_inv_place = go && (op == CBAOP_OP_INV_PLACE);
  wire do_inv_acc = go && (op == CBAOP_OP_INV_ACC);
  wire do_dec_adj = go && (op == CBAOP_OP_DEC_ADJ);
  wire do_wd_restart = go && (op == CBAOP_OP_WDRST);

  function automatic logic is_zero(input logic [7:0] v);
    return v == 8'h00;
  endfunction : is_zero

  // nibble needs plus six when above nine or flag set
  function automatic logic nibble_fix(input logic [3:0] nib, input logic flag);
    return (nib > CBAOP_BCD_MAX) || flag;
  endfunction : nibble_fix

  // nibble plus optional six, carry out in bit 4
  function automatic logic [4:0] nibble_add(input logic [3:0] nib, input logic fix, input logic cin);
    return {1'b0, nib} + {1'b0, (fix ? CBAOP_BCD_FIX : 4'h0)} + {4'h0, cin};
  endfunction : nibble_add

  // inverted operand
  wire [7:0] inv_val = ~mem_reg;

  wire lo_fix = nibble_fix(acc_reg[3:0], flags_reg.auxc);
  wire [4:0] lo_sum = nibble_add(acc_reg[3:0], lo_fix, 1'b0);
  wire hi_fix = nibble_fix(acc_reg[7:4], flags_reg.carry);
  wire [4:0] hi_sum = nibble_add(acc_reg[7:4], hi_fix, lo_sum[4]);
  wire [7:0] adj_val = {hi_sum[3:0], lo_sum[3:0]};
  wire adj_carry = hi_sum[4] || flags_reg.carry;

  // next values; an operation beats a same-cycle register write
  always_comb begin
    mem_next = mem_reg;
    acc_next = acc_reg;
    flags_next = flags_reg;
    if (wr_opnd) begin
      mem_next = pwdata[7:0];
    end
    if (wr_acc) begin
      acc_next = pwdata[7:0];
    end
    if (wr_st) begin
      flags_next.zero = pwdata[CBAOP_ST_ZERO_BIT];
      flags_next.auxc = pwdata[CBAOP_ST_AUXC_BIT];
      flags_next.carry = pwdata[CBAOP_ST_CARRY_BIT];
    end
    if (go) begin
      unique case (op)
        CBAOP_OP_INV_PLACE: begin
          mem_next = inv_val;
          flags_next.zero = is_zero(inv_val);
        end
        CBAOP_OP_INV_ACC: begin
          acc_next = inv_val;
          flags_next.zero = is_zero(inv_val);
        end
        CBAOP_OP_DEC_ADJ: begin
          mem_next = adj_val;
          flags_next.carry = adj_carry;
        end
        CBAOP_OP_WDRST: begin
          flags_next.wdto = 1'b0;
          flags_next.pdn = 1'b0;
        end
      endcase
    end
    // events come last so a set beats a restart clear
    if (watchdog_expire_evt) begin
      flags_next.wdto = 1'b1;
    end
    if (powerdown_evt) begin
      flags_next.pdn = 1'b1;
    end
  end

  assign wdclr_next = do_wd_restart;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_reg <= CBAOP_RST_BYTE;
    end else begin
      mem_reg <= mem_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_reg <= CBAOP_RST_BYTE;
    end else begin
      acc_reg <= acc_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= flags_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdclr_reg <= 1'b0;
    end else begin
      wdclr_reg <= wdclr_next;
    end
  end

  wire [31:0] st_word = {26'h0, wdclr_reg, flags_reg.pdn, flags_reg.wdto,
                         flags_reg.carry, flags_reg.auxc, flags_reg.zero};
  assign prdata = hit_opnd ? {24'h0, mem_reg} :
                  hit_acc ? {24'h0, acc_reg} :
                  hit_st ? st_word : CBAOP_RST_WORD;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign watchdog_clear = wdclr_reg;

  property p_inv_place;
    @(posedge pclk) disable iff (!presetn)
    (go && op == CBAOP_OP_INV_PLACE) |=> (mem_reg == ~$past(mem_reg)) && (flags_reg.zero == (mem_reg == 8'h00));
  endproperty
  a_inv_place: assert property (p_inv_place) else $error("invert in place wrong");

  property p_inv_acc;
    @(posedge pclk) disable iff (!presetn)
    (go && op == CBAOP_OP_INV_ACC) |=> (acc_reg == ~$past(mem_reg)) && $stable(mem_reg);
  endproperty
  a_inv_acc: assert property (p_inv_acc) else $error("invert to acc wrong");

  property p_lo_fix;
    @(posedge pclk) disable iff (!presetn)
    (do_dec_adj && !flags_reg.auxc && acc_reg[3:0] <= CBAOP_BCD_MAX)
      |=> mem_reg[3:0] == $past(acc_reg[3:0]);
  endproperty
  a_lo_fix: assert property (p_lo_fix) else $error("low nibble changed");

  property p_lo_add;
    @(posedge pclk) disable iff (!presetn)
    (do_dec_adj && acc_reg[3:0] > CBAOP_BCD_MAX)
      |=> mem_reg[3:0] == 4'($past(acc_reg[3:0]) + CBAOP_BCD_FIX);
  endproperty
  a_lo_add: assert property (p_lo_add) else $error("low nibble not corrected");

  property p_hi_fix;
    @(posedge pclk) disable iff (!presetn)
    (do_dec_adj && (acc_reg[7:4] > CBAOP_BCD_MAX || flags_reg.carry)) |=> flags_reg.carry;
  endproperty
  a_hi_fix: assert property (p_hi_fix) else $error("high fix missing carry");

  property p_hi_keep;
    @(posedge pclk) disable iff (!presetn)
    (do_dec_adj && !flags_reg.carry && acc_reg[7:4] <= CBAOP_BCD_MAX && acc_reg[3:0] <= CBAOP_BCD_MAX)
      |=> (mem_reg[7:4] == $past(acc_reg[7:4])) && !flags_reg.carry;
  endproperty
  a_hi_keep: assert property (p_hi_keep) else $error("high nibble changed");

  property p_hi_add;
    @(posedge pclk) disable iff (!presetn)
    (do_dec_adj && acc_reg[7:4] > CBAOP_BCD_MAX && acc_reg[3:0] <= CBAOP_BCD_MAX && !flags_reg.auxc)
      |=> mem_reg[7:4] == 4'($past(acc_reg[7:4]) + CBAOP_BCD_FIX);
  endproperty
  a_hi_add: assert property (p_hi_add) else $error("high nibble not corrected");

  property p_adj_sum;
    @(posedge pclk) disable iff (!presetn)
    do_dec_adj |=> (mem_reg - $past(acc_reg)) inside {8'h00, 8'h06, 8'h60, 8'h66};
  endproperty
  a_adj_sum: assert property (p_adj_sum) else $error("bad adjust amount");

  property p_adj_flags;
    @(posedge pclk) disable iff (!presetn)
    do_dec_adj |=> $stable(flags_reg.zero) && $stable(flags_reg.auxc) && $stable(acc_reg);
  endproperty
  a_adj_flags: assert property (p_adj_flags) else $error("adjust touched other state");

  property p_adj_keep_wd;
    @(posedge pclk) disable iff (!presetn)
    (do_dec_adj && !watchdog_expire_evt && !powerdown_evt)
      |=> $stable(flags_reg.wdto) && $stable(flags_reg.pdn);
  endproperty
  a_adj_keep_wd: assert property (p_adj_keep_wd) else $error("adjust touched watchdog flags");

  sequence s_wd_restart;
    do_wd_restart && !watchdog_expire_evt && !powerdown_evt;
  endsequence
  sequence s_clear_pulse;
    watchdog_clear ##1 (!watchdog_clear || $past(do_wd_restart));
  endsequence
  property p_wd_restart;
    @(posedge pclk) disable iff (!presetn)
    s_wd_restart |=> !flags_reg.wdto && !flags_reg.pdn ##0 s_clear_pulse;
  endproperty
  a_wd_restart: assert property (p_wd_restart) else $error("restart did not clear");

  property p_wdto_set;
    @(posedge pclk) disable iff (!presetn)
    watchdog_expire_evt |=> flags_reg.wdto;
  endproperty
  a_wdto_set: assert property (p_wdto_set) else $error("timeout event lost");

  property p_pdn_set;
    @(posedge pclk) disable iff (!presetn)
    powerdown_evt |=> flags_reg.pdn;
  endproperty
  a_pdn_set: assert property (p_pdn_set) else $error("powerdown event lost");

  property p_inv_keep_acc;
    @(posedge pclk) disable iff (!presetn)
    do_inv_place |=> $stable(acc_reg);
  endproperty
  a_inv_keep_acc: assert property (p_inv_keep_acc) else $error("invert in place touched acc");

  // writes with lane 0 off leave the location alone
  property p_strb_ignored;
    @(posedge pclk) disable iff (!presetn)
    (wr_en && hit_opnd && !pstrb[0]) |=> $stable(mem_reg);
  endproperty
  a_strb_ignored: assert property (p_strb_ignored) else $error("masked write landed");

  property p_ctrl_reads_zero;
    @(posedge pclk) disable iff (!presetn)
    (psel && hit_ctrl) |-> prdata == CBAOP_RST_WORD;
  endproperty
  a_ctrl_reads_zero: assert property (p_ctrl_reads_zero) else $error("control read not zero");

  property p_unmapped_err;
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && !mapped) |-> pslverr && (prdata == CBAOP_RST_WORD);
  endproperty
  a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped access not refused");

  property p_zero;
    @(posedge pclk) disable iff (!presetn)
    (go && op == CBAOP_OP_INV_ACC) |=> flags_reg.zero == (acc_reg == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

endmodule : cbaop_core
`default_nettype wire

/* hw/cbaop_pkg.sv */
`default_nettype none
package cbaop_pkg;

  // register byte offsets
  localparam logic [7:0] CBAOP_OFF_CTRL = 8'h00;
  localparam logic [7:0] CBAOP_OFF_OPERAND = 8'h04;
  localparam logic [7:0] CBAOP_OFF_ACC = 8'h08;
  localparam logic [7:0] CBAOP_OFF_STATUS = 8'h0C;

  // control register fields
  localparam int CBAOP_CTRL_OP_LSB = 0;
  localparam int CBAOP_CTRL_OP_W = 2;
  localparam int CBAOP_CTRL_GO_BIT = 2;

  // status register fields
  localparam int CBAOP_ST_ZERO_BIT = 0;
  localparam int CBAOP_ST_AUXC_BIT = 1;
  localparam int CBAOP_ST_CARRY_BIT = 2;
  localparam int CBAOP_ST_WDTO_BIT = 3;
  localparam int CBAOP_ST_PDN_BIT = 4;
  localparam int CBAOP_ST_WDCLR_BIT = 5;

  // reset values
  localparam logic [7:0] CBAOP_RST_BYTE = 8'h00;
  localparam logic [31:0] CBAOP_RST_WORD = 32'h0000_0000;

  // decimal adjust constants
  localparam logic [3:0] CBAOP_BCD_MAX = 4'h9;
  localparam logic [3:0] CBAOP_BCD_FIX = 4'h6;

  typedef enum logic [1:0] {
    CBAOP_OP_INV_PLACE,
    CBAOP_OP_INV_ACC,
    CBAOP_OP_DEC_ADJ,
    CBAOP_OP_WDRST
  } cbaop_op_t;

  typedef struct packed {
    logic zero;
    logic auxc;
    logic carry;
    logic wdto;
    logic pdn;
  } cbaop_flags_t;

endpackage : cbaop_pkg
`default_nettype wire

/* testbench/cbaop_core_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module cbaop_core_tb
  import cbaop_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, wde = 0, pde = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata, rd;
  logic pready, pslverr, wclr, err;
  int mismatches = 0, tests_run = 0, cyc = 0, nclr = 0;
  int mem, acc, z, ac, c, corr, sum, op;
  always #2.5 pclk = ~pclk;
  cbaop_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .watchdog_expire_evt(wde), .powerdown_evt(pde), .watchdog_clear(wclr));
  task print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (wclr === 1'b1) nclr <= nclr + 1;
    if (cyc > 20000) begin
      mismatches++;
      print_verdict();
    end
  end
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // setup, access until pready, then one idle cycle
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task pulse(input int which);
    if (which == 0) wde <= 1'b1; else pde <= 1'b1;
    @(posedge pclk);
    wde <= 1'b0; pde <= 1'b0;
    @(posedge pclk);
  endtask : pulse
  initial begin
    void'($urandom(29));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, CBAOP_OFF_STATUS, 0);
    chk("status after reset", rd, 32'h0000_0000);
    for (int i = 0; i < 30; i++) begin
      mem = (i < 3) ? 255 : $urandom_range(255);
      acc = $urandom_range(255); ac = $urandom_range(1); c = $urandom_range(1); z = $urandom_range(1);
      op = i % 3;
      apb(1, CBAOP_OFF_OPERAND, mem);
      apb(1, CBAOP_OFF_ACC, acc);
      apb(1, CBAOP_OFF_STATUS, z | (ac << 1) | (c << 2));
      apb(1, CBAOP_OFF_CTRL, 4 | op);
      case (op)
        0: begin mem = ~mem & 255; z = (mem == 0); end
        1: begin acc = ~mem & 255; z = (acc == 0); end
        default: begin
          corr = (((acc & 15) > 9) || ac) ? 6 : 0;
          corr += (((acc >> 4) > 9) || c) ? 'h60 : 0;
          sum = acc + corr;
          mem = sum & 255;
          c = c | (sum > 255);
        end
      endcase
      apb(0, CBAOP_OFF_OPERAND, 0);
      chk("memory", rd, mem);
      apb(0, CBAOP_OFF_ACC, 0);
      chk("accumulator", rd, acc);
      apb(0, CBAOP_OFF_STATUS, 0);
      chk("flags", rd, z | (ac << 1) | (c << 2));
    end
    $display("test operations done");
    pulse(0);
    pulse(1);
    apb(0, CBAOP_OFF_STATUS, 0);
    chk("timeout and powerdown set", rd[4:3], 2'b11);
    apb(1, CBAOP_OFF_CTRL, 4 | 3);
    apb(0, CBAOP_OFF_STATUS, 0);
    chk("timeout and powerdown cleared", rd[4:3], 2'b00);
    chk("restart pulses", nclr, 1);
    // event only at the restart's access edge: the set must win
    fork
      apb(1, CBAOP_OFF_CTRL, 4 | 3);
      begin
        @(posedge pclk);
        wde <= 1'b1;
        @(posedge pclk);
        wde <= 1'b0;
      end
    join
    apb(0, CBAOP_OFF_STATUS, 0);
    chk("set beats restart", rd[4:3], 2'b01);
    $display("test watchdog restart done");
    pstrb <= 4'h0;
    apb(1, CBAOP_OFF_OPERAND, ~mem & 255);
    pstrb <= 4'hF;
    apb(0, CBAOP_OFF_OPERAND, 0);
    chk("lane 0 strobe low", rd, mem);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, CBAOP_OFF_OPERAND, 0);
    chk("memory after mid reset", rd, 0);
    apb(0, CBAOP_OFF_STATUS, 0);
    chk("status after mid reset", rd, 0);
    $display("test strobe and mid reset done");
    apb(0, 8'h10, 0);
    chk("unmapped error", err, 1);
    chk("unmapped data", rd, 0);
    chk("ready", pready, 1);
    $display("test unmapped access done");
    print_verdict();
  end
endmodule : cbaop_core_tb
`default_nettype wire
